// File: core/power_button_state_control.sv
// power button driven soft-off / working / sleeping state controller
// Operation
// - A short press and release while soft-off powers the system up into working.
// - A short press while working requests sleep.
// - That short-press outcome follows the OS policy input, which may pick off or nothing instead.
// - Holding the switch over six seconds while working forces soft-off with no software involvement.
// - A short press while sleeping wakes the system into working.
// - Holding the switch over six seconds while sleeping goes straight to soft-off.
// - An OS soft-off request removes main power.
// - On return of main power the stored policy picks power on, stay off or last state.
// - Power switch and RTC alarm wake from suspend-to-RAM, suspend-to-disk and soft-off.
// - A network wake signal powers the computer up.
// - USB activity wakes from suspend-to-RAM, except after a main power loss.
`timescale 1ns/1ps
module power_button_state_control
(
   // clock and standby reset
   input  wire logic       CLK_IN,
   input  wire logic       RESET_N_IN,
   // front panel switch, low while pressed
   input  wire logic       PWR_SW_N_IN,
   // main power and restore policy
   input  wire logic       MAIN_PWR_OK_IN,
   input  wire logic [1:0] RESTORE_POLICY_IN,
   // operating system requests
   input  wire logic       OS_SOFT_OFF_REQ_IN,
   input  wire logic       OS_SLEEP_REQ_IN,
   input  wire logic [1:0] OS_SLEEP_DEPTH_IN,
   input  wire logic [1:0] OS_SHORT_POLICY_IN,
   // wake sources
   input  wire logic       RTC_ALARM_IN,
   input  wire logic       LAN_WAKE_IN,
   input  wire logic       USB_WAKE_IN,
   // state and rails
   output logic            MAIN_PWR_EN_OUT,
   output logic [1:0]      SYS_STATE_OUT,
   output logic            SLEEP_DISK_OUT,
   output logic            SLEEP_REQ_OUT
);

   localparam int unsigned NSYNC = 7;

   logic [NSYNC-1:0] meta_q;
   logic [NSYNC-1:0] sync_q;
   // static settings ride the same two-flop pipeline, so they line up with the request they qualify
   logic [1:0]       pol_meta_q;
   logic [1:0]       pol_sync_q;
   logic [1:0]       dep_meta_q;
   logic [1:0]       dep_sync_q;
   logic [1:0]       spol_meta_q;
   logic [1:0]       spol_sync_q;
   logic             sw_pressed;
   logic             pwr_ok;
   logic             pwr_ok_q;
   logic             os_off;
   logic             os_sleep;
   logic             os_off_q;
   logic             os_sleep_q;
   logic             os_off_evt;
   logic             os_sleep_evt;
   pwr_state_pkg::wake_src_t  wake;
   pwr_state_pkg::wake_src_t  wake_q;
   pwr_state_pkg::wake_src_t  wake_evt;
   pwr_state_pkg::press_evt_t press;
   pwr_state_pkg::sys_state_t state_q;
   pwr_state_pkg::sys_state_t state_d;
   pwr_state_pkg::sys_state_t last_q;
   logic             after_loss_q;
   logic             disk_q;
   logic             main_en_q;
   logic             sleep_req_q;

   // every pin crosses in through two flops before use
   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         meta_q      <= '0;
         sync_q      <= '0;
         pol_meta_q  <= '0;
         pol_sync_q  <= '0;
         dep_meta_q  <= '0;
         dep_sync_q  <= '0;
         spol_meta_q <= '0;
         spol_sync_q <= '0;
      end
      else
      begin
         meta_q <= {!PWR_SW_N_IN, MAIN_PWR_OK_IN, OS_SOFT_OFF_REQ_IN, OS_SLEEP_REQ_IN,
                    RTC_ALARM_IN, LAN_WAKE_IN, USB_WAKE_IN};
         sync_q <= meta_q;
         pol_meta_q  <= RESTORE_POLICY_IN;
         pol_sync_q  <= pol_meta_q;
         dep_meta_q  <= OS_SLEEP_DEPTH_IN;
         dep_sync_q  <= dep_meta_q;
         spol_meta_q <= OS_SHORT_POLICY_IN;
         spol_sync_q <= spol_meta_q;
      end
   end

   assign sw_pressed = sync_q[6];
   assign pwr_ok     = sync_q[5];
   assign os_off     = sync_q[4];
   assign os_sleep   = sync_q[3];
   assign wake       = sync_q[2:0];

   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         pwr_ok_q   <= 1'b0;
         os_off_q   <= 1'b0;
         os_sleep_q <= 1'b0;
         wake_q     <= '0;
      end
      else
      begin
         pwr_ok_q   <= pwr_ok;
         os_off_q   <= os_off;
         os_sleep_q <= os_sleep;
         wake_q     <= wake;
      end
   end

   // wake and OS requests act on rising edges, so a held level fires once
   assign os_off_evt   = os_off && !os_off_q;
   assign os_sleep_evt = os_sleep && !os_sleep_q;
   assign wake_evt     = wake & ~wake_q;

   press_timer u_press
   (
      .clk     (CLK_IN),
      .reset_n (RESET_N_IN),
      .pressed (sw_pressed && pwr_ok),
      .evt     (press)
   );

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         pwr_state_pkg::ST_LOSS:
         begin
            if (pwr_ok)
            begin
               case (pol_sync_q)
                  pwr_state_pkg::POLICY_POWER_ON: state_d = pwr_state_pkg::ST_WORK;
                  pwr_state_pkg::POLICY_STAY_OFF: state_d = pwr_state_pkg::ST_OFF;
                  pwr_state_pkg::POLICY_LAST:     state_d = last_q;
                  default:                        state_d = pwr_state_pkg::ST_OFF;
               endcase
            end
         end
         pwr_state_pkg::ST_OFF:
         begin
            if (press.short_rel || wake_evt.rtc_alarm)
               state_d = pwr_state_pkg::ST_WORK;
            else if (wake_evt.lan_wake)
               state_d = pwr_state_pkg::ST_WORK;
         end
         pwr_state_pkg::ST_WORK:
         begin
            if (press.long_hold || os_off_evt)
               state_d = pwr_state_pkg::ST_OFF;
            else if (press.short_rel)
            begin
               case (spol_sync_q)
                  pwr_state_pkg::SHORT_DO_SLEEP: state_d = pwr_state_pkg::ST_SLEEP;
                  pwr_state_pkg::SHORT_DO_OFF:   state_d = pwr_state_pkg::ST_OFF;
                  default:                       state_d = pwr_state_pkg::ST_WORK;
               endcase
            end
            else if (os_sleep_evt)
               state_d = pwr_state_pkg::ST_SLEEP;
         end
         pwr_state_pkg::ST_SLEEP:
         begin
            if (press.long_hold)
               state_d = pwr_state_pkg::ST_OFF;
            else if (press.short_rel || wake_evt.rtc_alarm || wake_evt.lan_wake)
               state_d = pwr_state_pkg::ST_WORK;
            else if (wake_evt.usb_wake && !disk_q && !after_loss_q)
               state_d = pwr_state_pkg::ST_WORK;
         end
         default: state_d = pwr_state_pkg::ST_OFF;
      endcase
      // loss of main power overrides everything
      if (!pwr_ok)
         state_d = pwr_state_pkg::ST_LOSS;
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         state_q <= pwr_state_pkg::ST_LOSS;
      else
         state_q <= state_d;
   end

   // last state is kept in standby, so it survives the main power loss
   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         last_q <= pwr_state_pkg::ST_OFF;
      else if (state_q != pwr_state_pkg::ST_LOSS)
         last_q <= state_q;
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         after_loss_q <= 1'b1;
      else if (!pwr_ok)
         after_loss_q <= 1'b1;
      else if (state_q == pwr_state_pkg::ST_WORK)
         after_loss_q <= 1'b0;
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         disk_q <= 1'b0;
      else if (state_q == pwr_state_pkg::ST_WORK && state_d == pwr_state_pkg::ST_SLEEP)
         disk_q <= os_sleep_evt && (dep_sync_q == pwr_state_pkg::SLEEP_DISK);
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         main_en_q   <= 1'b0;
         sleep_req_q <= 1'b0;
      end
      else
      begin
         main_en_q   <= (state_d == pwr_state_pkg::ST_WORK);
         sleep_req_q <= (state_d == pwr_state_pkg::ST_SLEEP);
      end
   end

   assign MAIN_PWR_EN_OUT = main_en_q;
   assign SYS_STATE_OUT   = state_q;
   assign SLEEP_DISK_OUT  = disk_q;
   assign SLEEP_REQ_OUT   = sleep_req_q;

endmodule : power_button_state_control

// File: core/pwr_state_pkg.sv
// shared types and constants for the power button state controller
package pwr_state_pkg;

   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned SHORT_PRESS_S   = 4;
   localparam int unsigned LONG_PRESS_S    = 6;
   localparam int unsigned TICK_MS         = 1;
   localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned SHORT_PRESS_TICKS = SHORT_PRESS_S * 1000 / TICK_MS;
   localparam int unsigned LONG_PRESS_TICKS  = LONG_PRESS_S * 1000 / TICK_MS;
   localparam int unsigned TICK_W          = 16;
   localparam int unsigned PRESS_W         = 14;

   // power restore policy encodings
   localparam logic [1:0] POLICY_POWER_ON  = 2'h0;
   localparam logic [1:0] POLICY_STAY_OFF  = 2'h1;
   localparam logic [1:0] POLICY_LAST      = 2'h2;

   // sleep depth requested by the operating system
   localparam logic [1:0] SLEEP_RAM        = 2'h0;
   localparam logic [1:0] SLEEP_DISK       = 2'h1;

   // outcome of a short press while working, chosen by OS policy
   localparam logic [1:0] SHORT_DO_SLEEP   = 2'h0;
   localparam logic [1:0] SHORT_DO_OFF     = 2'h1;
   localparam logic [1:0] SHORT_DO_NOTHING = 2'h2;

   typedef enum logic [1:0]
   {
      ST_OFF   = 2'h0,
      ST_WORK  = 2'h1,
      ST_SLEEP = 2'h3,
      ST_LOSS  = 2'h2
   } sys_state_t;

   // classified press, one-cycle events
   typedef struct packed
   {
      logic short_rel;
      logic long_hold;
   } press_evt_t;

   // wake sources, all synchronised
   typedef struct packed
   {
      logic rtc_alarm;
      logic lan_wake;
      logic usb_wake;
   } wake_src_t;

endpackage : pwr_state_pkg

// File: core/press_timer.sv
// debounced-free press duration classifier for the power switch
`timescale 1ns/1ps
module press_timer
(
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   input  wire logic                    pressed,
   output pwr_state_pkg::press_evt_t    evt
);

   logic [pwr_state_pkg::TICK_W-1:0]  tick_cnt_q;
   logic                              tick;
   logic [pwr_state_pkg::PRESS_W-1:0] held_q;
   logic                              long_done_q;
   logic                              pressed_q;

   assign tick = (tick_cnt_q == pwr_state_pkg::TICK_W'(pwr_state_pkg::TICK_CYCLES - 1));

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         tick_cnt_q <= '0;
      else if (tick)
         tick_cnt_q <= '0;
      else
         tick_cnt_q <= tick_cnt_q + 1'b1;
   end

   // duration saturates so a stuck switch cannot wrap into a short press
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         held_q <= '0;
      else if (!pressed)
         held_q <= '0;
      else if (tick && held_q != '1)
         held_q <= held_q + 1'b1;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         pressed_q <= 1'b0;
      else
         pressed_q <= pressed;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         long_done_q <= 1'b0;
      else if (!pressed)
         long_done_q <= 1'b0;
      else if (held_q > pwr_state_pkg::PRESS_W'(pwr_state_pkg::LONG_PRESS_TICKS))
         long_done_q <= 1'b1;
   end

   // 4..6 s releases give neither event
   assign evt.short_rel = pressed_q && !pressed
                          && held_q < pwr_state_pkg::PRESS_W'(pwr_state_pkg::SHORT_PRESS_TICKS);
   assign evt.long_hold = pressed && !long_done_q
                          && held_q > pwr_state_pkg::PRESS_W'(pwr_state_pkg::LONG_PRESS_TICKS);

endmodule : press_timer

// File: dv/power_button_state_control_monitor.sv
// port-level assertions for the power button state controller
`timescale 1ns/1ps
module power_button_state_control_monitor
(
   // clock, reset and stimulus
   input  wire logic       CLK_IN,
   input  wire logic       RESET_N_IN,
   input  wire logic       PWR_SW_N_IN,
   input  wire logic       MAIN_PWR_OK_IN,
   input  wire logic       OS_SOFT_OFF_REQ_IN,
   input  wire logic       LAN_WAKE_IN,
   input  wire logic [1:0] OS_SHORT_POLICY_IN,
   // observed outputs
   input  wire logic [1:0] SYS_STATE_OUT,
   input  wire logic       MAIN_PWR_EN_OUT
);
   // one tick of margin below the short limit and two ticks above the long limit absorb the tick phase
   localparam int SC = (pwr_state_pkg::SHORT_PRESS_TICKS - 1) * pwr_state_pkg::TICK_CYCLES;
   localparam int LC = (pwr_state_pkg::LONG_PRESS_TICKS + 2) * pwr_state_pkg::TICK_CYCLES;
   logic [31:0] cnt_q;
   logic        sw_q;
   logic        rel;
   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         cnt_q <= 32'h0;
      else
         cnt_q <= PWR_SW_N_IN ? 32'h0 : cnt_q + 32'h1;
   end
   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         sw_q <= 1'b1;
      else
         sw_q <= PWR_SW_N_IN;
   end
   assign rel = PWR_SW_N_IN & ~sw_q & MAIN_PWR_OK_IN & (cnt_q < SC);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   property p_en;
      MAIN_PWR_EN_OUT == (SYS_STATE_OUT == pwr_state_pkg::ST_WORK);
   endproperty
   a_en: assert property (p_en) else $error("rail enable disagrees with state");
   property p_loss;
      $fell(MAIN_PWR_OK_IN) |-> ##[1:4] SYS_STATE_OUT == pwr_state_pkg::ST_LOSS;
   endproperty
   a_loss: assert property (p_loss) else $error("power loss not seen");
   property p_off;
      rel && SYS_STATE_OUT == pwr_state_pkg::ST_OFF |-> ##[1:4] SYS_STATE_OUT == pwr_state_pkg::ST_WORK;
   endproperty
   a_off: assert property (p_off) else $error("short press did not power up");
   property p_slp;
      rel && SYS_STATE_OUT == pwr_state_pkg::ST_SLEEP |-> ##[1:4] SYS_STATE_OUT == pwr_state_pkg::ST_WORK;
   endproperty
   a_slp: assert property (p_slp) else $error("short press did not wake");
   property p_sl;
      rel && SYS_STATE_OUT == pwr_state_pkg::ST_WORK && OS_SHORT_POLICY_IN == pwr_state_pkg::SHORT_DO_SLEEP
      |-> ##[1:4] SYS_STATE_OUT == pwr_state_pkg::ST_SLEEP;
   endproperty
   a_sl: assert property (p_sl) else $error("short press did not sleep");
   property p_so;
      rel && SYS_STATE_OUT == pwr_state_pkg::ST_WORK && OS_SHORT_POLICY_IN == pwr_state_pkg::SHORT_DO_OFF
      |-> ##[1:4] SYS_STATE_OUT == pwr_state_pkg::ST_OFF;
   endproperty
   a_so: assert property (p_so) else $error("short press did not power off");
   property p_os;
      $rose(OS_SOFT_OFF_REQ_IN) && SYS_STATE_OUT == pwr_state_pkg::ST_WORK |-> ##[1:4] !MAIN_PWR_EN_OUT;
   endproperty
   a_os: assert property (p_os) else $error("soft-off request kept power");
   property p_lan;
      $rose(LAN_WAKE_IN) && SYS_STATE_OUT == pwr_state_pkg::ST_OFF |-> ##[1:4] MAIN_PWR_EN_OUT;
   endproperty
   a_lan: assert property (p_lan) else $error("network wake ignored");
   property p_lg;
      cnt_q == LC |-> SYS_STATE_OUT inside {pwr_state_pkg::ST_OFF, pwr_state_pkg::ST_LOSS};
   endproperty
   a_lg: assert property (p_lg) else $error("long hold did not power off");
endmodule : power_button_state_control_monitor
bind power_button_state_control power_button_state_control_monitor u_mon (.*);

// File: dv/pwr_partner.sv
// model of the front panel switch and the operating system soft-off and sleep requests
`timescale 1ns/1ps
module pwr_partner
(
   input  wire logic clk,
   output logic      sw_n,
   output logic      off_req,
   output logic      slp_req
);
   initial {sw_n, off_req, slp_req} = 3'h4;
   task automatic press(input int n);
      @(posedge clk);
      #1 sw_n = 1'b0;
      repeat (n) @(posedge clk);
      #1 sw_n = 1'b1;
   endtask : press
   // held four cycles so the two-flop synchroniser surely sees it
   task automatic pulse(input logic off);
      @(posedge clk);
      #1 if (off) off_req = 1'b1; else slp_req = 1'b1;
      repeat (4) @(posedge clk);
      #1 {off_req, slp_req} = 2'h0;
   endtask : pulse
endmodule : pwr_partner

// File: dv/power_button_state_control_tb.sv
// self-checking bench for the power button state controller
`timescale 1ns/1ps
module power_button_state_control_tb;
   localparam logic [1:0] OFF = pwr_state_pkg::ST_OFF;
   localparam logic [1:0] WRK = pwr_state_pkg::ST_WORK;
   localparam logic [1:0] SLP = pwr_state_pkg::ST_SLEEP;
   localparam logic [1:0] LOS = pwr_state_pkg::ST_LOSS;
   logic       clk, rst_n, sw_n, ok, off_r, slp_r, rtc, lan, usb, en, disk, sreq;
   logic [1:0] pol, dep, spol, st, last;
   logic [1:0] q[$];
   int         error_cnt, checks;
   pwr_partner u_par (.clk(clk), .sw_n(sw_n), .off_req(off_r), .slp_req(slp_r));
   power_button_state_control u_dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .PWR_SW_N_IN(sw_n),
      .MAIN_PWR_OK_IN(ok), .RESTORE_POLICY_IN(pol), .OS_SOFT_OFF_REQ_IN(off_r), .OS_SLEEP_REQ_IN(slp_r),
      .OS_SLEEP_DEPTH_IN(dep), .OS_SHORT_POLICY_IN(spol), .RTC_ALARM_IN(rtc), .LAN_WAKE_IN(lan),
      .USB_WAKE_IN(usb), .MAIN_PWR_EN_OUT(en), .SYS_STATE_OUT(st), .SLEEP_DISK_OUT(disk),
      .SLEEP_REQ_OUT(sreq));
   task automatic cmp(input logic [1:0] g, input logic [1:0] e);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task final_report;
      $display("mismatches=%0d comparisons=%0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   task wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   // the note must be queued before the stimulus whose answer can arrive while the driver still holds it
   task note(input logic [1:0] e);
      q.push_back(e);
   endtask : note
   // wait for the watcher to take the note, then check the rail against the state reached
   task drain(input logic [1:0] e);
      for (int i = 0; i < 60 && q.size() > 0; i++)
         wt(1);
      if (q.size() > 0)
      begin
         error_cnt++;
         final_report;
      end
      cmp({1'b0, en}, {1'b0, e == WRK});
   endtask : drain
   task go(input logic [1:0] e);
      note(e);
      drain(e);
   endtask : go
   task hold(input logic [1:0] e);
      wt(20);
      cmp(st, e);
   endtask : hold
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // any state change with no note queued is a mismatch against the old state
   always @(posedge clk)
   begin
      #2;
      if (rst_n === 1'b1 && st !== last)
         cmp(st, (q.size() > 0) ? q.pop_front() : last);
      last = st;
   end
   initial
   begin
      {rst_n, rtc, lan, usb, dep, spol} = 8'h0;
      {ok, pol} = 3'h5;
      error_cnt = 0;
      checks = 0;
      void'($urandom(32'h33A2FEA4));
      wt(2);
      cmp(st, LOS);
      rst_n = 1'b1;
      go(OFF);
      u_par.press(5 + $urandom % 200); go(WRK);
      u_par.press(5 + $urandom % 200); go(SLP);
      cmp({1'b0, sreq}, 2'h1);
      cmp({1'b0, disk}, 2'h0);
      usb = 1'b1; go(WRK); usb = 1'b0;
      spol = 2'h1; u_par.press(5 + $urandom % 200); go(OFF);
      lan = 1'b1; go(WRK); lan = 1'b0;
      spol = 2'h2; u_par.press(5 + $urandom % 200); hold(WRK);
      dep = 2'h1; note(SLP); u_par.pulse(1'b0); drain(SLP);
      cmp({1'b0, disk}, 2'h1);
      usb = 1'b1; hold(SLP); usb = 1'b0;
      rtc = 1'b1; go(WRK); rtc = 1'b0;
      note(SLP); u_par.pulse(1'b0); drain(SLP); u_par.press(5 + $urandom % 200); go(WRK);
      note(OFF); u_par.pulse(1'b1); drain(OFF);
      rtc = 1'b1; go(WRK); rtc = 1'b0;
      pol = 2'h2; ok = 1'b0; go(LOS); ok = 1'b1; go(WRK);
      pol = 2'h0; note(OFF); u_par.pulse(1'b1); drain(OFF); ok = 1'b0; go(LOS); ok = 1'b1; go(WRK);
      pol = 2'h1; ok = 1'b0; go(LOS); ok = 1'b1; go(OFF);
      usb = 1'b1; hold(OFF); usb = 1'b0;
      final_report;
   end
endmodule : power_button_state_control_tb
